// ### verilog/fsc_map.vh
`ifndef FSC_MAP_VH
`define FSC_MAP_VH
`define FSC_SEC_ADDR 18'h3FF0F
`define FSC_KEY_ADDR0 18'h3FF00
`define FSC_SEC_UNSECURE 2'h2
`define FSC_SEC_SECURED 2'h3
`define FSC_KEY_ACCESS_ENABLE_ON 2'h2
`define FSC_KEY_ZERO 16'h0000
`define FSC_KEY_ONES 16'hFFFF
`define FSC_SEC_DEFAULT 8'hFF
`define FSC_PROT_DEFAULT 8'h00
`define FSC_OPT_DEFAULT 8'hFF
`define FSC_HOLD_CYCLES 4'h8
`define FSC_FIELD_WORDS 3'h4
`define FSC_VFAULT_BOTH 2'h3
`define FSC_VFAULT_NONE 2'h0
`endif

// ### verilog/fsc_ctrl.v
`timescale 1ns/100ps
`include "fsc_map.vh"
// Operation
// - command irq when done flag and enable
// - error irq from enabled double/single faults
// - stop held until active command finishes
// - reset loads security from config byte
// - new security byte effective after reset
// - key match forces security field to 10
// - keys 0000 or FFFF never valid
// - flash reads blocked during key verify
// - failed key locks verify until reset
// - key verify keeps stored bytes, protections
// - erased-all in special mode unsecures
// - reset errors give protected secured defaults
// - reset double fault sets both verify bits
// - done flag clear until init finishes
// - cpu stalled in first init phase
// - command writes ignored until init done
// - reset aborts running command immediately
// - clearing done launches; set on finish
module fsc_ctrl (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  // cpu side
  input wire cmd_launch,
  input wire cmd_is_key_verify,
  input wire [63:0] key_presented,
  input wire cmd_reg_wr,
  input wire cmd_done_irq_en,
  input wire dbl_fault_irq_en,
  input wire sgl_fault_irq_en,
  input wire dbl_fault_clr,
  input wire sgl_fault_clr,
  input wire stop_req,
  input wire special_mode,
  input wire erase_verify_all_ok,
  // array side
  output reg arr_rd_req,
  output reg [17:0] arr_rd_addr,
  input wire arr_rd_valid,
  input wire [15:0] arr_rd_data,
  input wire arr_dbl_fault,
  input wire arr_sgl_fault,
  input wire arr_op_busy,
  output reg arr_op_start,
  output wire arr_op_abort,
  // status
  output reg cmd_done_flag,
  output reg dbl_fault_flag,
  output reg sgl_fault_flag,
  output reg [1:0] verify_fault_bits,
  output reg [7:0] security_reg,
  output reg [7:0] program_protect_reg,
  output reg [7:0] data_protect_reg,
  output reg [7:0] option_reg,
  output wire [1:0] security_state_field,
  output wire [1:0] key_access_enable,
  output reg key_verify_locked_r,
  output wire cmd_irq,
  output wire err_irq,
  output wire stop_ack,
  output wire cpu_stall,
  output wire cmd_wr_accept,
  output wire read_block
);
////////////////////////////////////////////////////////////////////////////////
localparam ST_HOLD = 3'h0;
localparam ST_LOAD = 3'h1;
localparam ST_WAIT = 3'h2;
localparam ST_IDLE = 3'h3;
localparam ST_KEY = 3'h4;
localparam ST_RUN = 3'h5;
reg [2:0] state_r;
reg [3:0] hold_cnt_r;
reg [2:0] word_r;
reg [63:0] keys_r;
reg init_err_r;
reg [1:0] sec_live_r;
wire key_ok;
wire key_bad_val;
assign security_state_field = sec_live_r;
assign key_access_enable = security_reg[7:6];
// the command block is fed by an external pulse, so abort is the reset
assign arr_op_abort = reset;
assign cmd_irq = cmd_done_flag & cmd_done_irq_en;
assign err_irq = (dbl_fault_flag & dbl_fault_irq_en) |
  (sgl_fault_flag & sgl_fault_irq_en);
assign stop_ack = stop_req & cmd_done_flag;
assign cpu_stall = (state_r == ST_HOLD);
assign cmd_wr_accept = cmd_reg_wr & (state_r == ST_IDLE) &
  cmd_done_flag;
assign read_block = (state_r == ST_KEY);
genvar gi;
wire [3:0] bad_w;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
    assign bad_w[gi] = (keys_r[gi*16 +: 16] == `FSC_KEY_ZERO) |
      (keys_r[gi*16 +: 16] == `FSC_KEY_ONES);
  end
endgenerate
assign key_bad_val = |bad_w;
assign key_ok = ~key_bad_val & (keys_r == key_presented);
////////////////////////////////////////////////////////////////////////////////
// next values; each register below except the protections and options takes its value from one of these

reg [2:0] state_nxt;
reg [3:0] hold_cnt_nxt;
reg [2:0] word_nxt;
reg [63:0] keys_nxt;
reg init_err_nxt;
reg rd_req_nxt;
reg [17:0] rd_addr_nxt;
reg op_start_nxt;

reg [1:0] sec_live_nxt;
reg cmd_done_nxt;
reg dbl_fault_nxt;
reg sgl_fault_nxt;
reg [1:0] verify_fault_nxt;
reg [7:0] security_nxt;
reg lock_nxt;

wire init_done;
wire launch_take;

// fault flags start to capture only once the reset sequence is over
assign init_done = (state_r > ST_WAIT);
// a launch outside idle or with the flag low is simply dropped
assign launch_take = cmd_launch & cmd_done_flag & (state_r == ST_IDLE);

////////////////////////////////////////////////////////////////////////////////
// a fault in the cycle of its clear wins, so no event in a cycle with clk_en high after the reset sequence is lost
always @* begin
  dbl_fault_nxt = dbl_fault_flag;
  if (arr_dbl_fault & init_done)
    dbl_fault_nxt = 1'b1;
  else if (dbl_fault_clr)
    dbl_fault_nxt = 1'b0;
end

always @* begin
  sgl_fault_nxt = sgl_fault_flag;
  if (arr_sgl_fault & init_done)
    sgl_fault_nxt = 1'b1;
  else if (sgl_fault_clr)
    sgl_fault_nxt = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// reset sequence reads keys then the security byte; a double fault falls back to
// fully secured defaults since trusting a damaged byte could unsecure
always @* begin
  state_nxt = state_r;
  hold_cnt_nxt = hold_cnt_r;
  word_nxt = word_r;
  keys_nxt = keys_r;
  init_err_nxt = init_err_r;
  rd_req_nxt = arr_rd_req;
  rd_addr_nxt = arr_rd_addr;
  op_start_nxt = 1'b0;
  sec_live_nxt = sec_live_r;
  cmd_done_nxt = cmd_done_flag;
  verify_fault_nxt = verify_fault_bits;
  security_nxt = security_reg;
  lock_nxt = key_verify_locked_r;

  case (state_r)
    ST_HOLD: begin
      hold_cnt_nxt = hold_cnt_r + 4'h1;
      if (hold_cnt_r == `FSC_HOLD_CYCLES - 4'h1)
        state_nxt = ST_LOAD;
    end

    ST_LOAD: begin
      rd_req_nxt = 1'b1;
      if (word_r == `FSC_FIELD_WORDS)
        rd_addr_nxt = `FSC_SEC_ADDR;
      else
        rd_addr_nxt = `FSC_KEY_ADDR0 + {14'h0, word_r, 1'b0};
      state_nxt = ST_WAIT;
    end

    ST_WAIT: begin
      if (arr_rd_valid) begin
        rd_req_nxt = 1'b0;
        if (arr_dbl_fault) begin
          verify_fault_nxt = `FSC_VFAULT_BOTH;
          init_err_nxt = 1'b1;
        end
        if (word_r == `FSC_FIELD_WORDS) begin
          if (init_err_r | arr_dbl_fault) begin
            security_nxt = `FSC_SEC_DEFAULT;
            sec_live_nxt = `FSC_SEC_SECURED;
          end else begin
            security_nxt = arr_rd_data[7:0];
            sec_live_nxt = arr_rd_data[1:0];
          end
          cmd_done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          keys_nxt[word_r*16 +: 16] = arr_rd_data;
          word_nxt = word_r + 3'h1;
          state_nxt = ST_LOAD;
        end
      end
    end

    ST_IDLE: begin
      if (special_mode & erase_verify_all_ok)
        sec_live_nxt = `FSC_SEC_UNSECURE;
      if (launch_take) begin
        cmd_done_nxt = 1'b0;
        verify_fault_nxt = `FSC_VFAULT_NONE;
        if (cmd_is_key_verify) begin
          if (key_verify_locked_r |
              key_access_enable != `FSC_KEY_ACCESS_ENABLE_ON)
            cmd_done_nxt = 1'b1;
          else
            state_nxt = ST_KEY;
        end else begin
          op_start_nxt = 1'b1;
          state_nxt = ST_RUN;
        end
      end
    end

    ST_KEY: begin
      // only the live field or the lock changes; stored byte and protections stay
      if (key_ok)
        sec_live_nxt = `FSC_SEC_UNSECURE;
      else
        lock_nxt = 1'b1;
      cmd_done_nxt = 1'b1;
      state_nxt = ST_IDLE;
    end

    ST_RUN: begin
      // the start pulse is still out in the first cycle, busy not yet seen
      if (~arr_op_busy & ~arr_op_start) begin
        cmd_done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    end

    default: state_nxt = ST_HOLD;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// sequencer registers
always @(posedge core_clk or posedge reset) begin
  if (reset) begin
    state_r <= ST_HOLD;
    hold_cnt_r <= 4'h0;
    word_r <= 3'h0;
    keys_r <= 64'h0;
    init_err_r <= 1'b0;
    arr_rd_req <= 1'b0;
    arr_rd_addr <= 18'h0;
    arr_op_start <= 1'b0;
  end else if (clk_en) begin
    state_r <= state_nxt;
    hold_cnt_r <= hold_cnt_nxt;
    word_r <= word_nxt;
    keys_r <= keys_nxt;
    init_err_r <= init_err_nxt;
    arr_rd_req <= rd_req_nxt;
    arr_rd_addr <= rd_addr_nxt;
    arr_op_start <= op_start_nxt;
  end
end

// status bits seen by the cpu
always @(posedge core_clk or posedge reset) begin
  if (reset) begin
    cmd_done_flag <= 1'b0;
    dbl_fault_flag <= 1'b0;
    sgl_fault_flag <= 1'b0;
    verify_fault_bits <= `FSC_VFAULT_NONE;
    security_reg <= `FSC_SEC_DEFAULT;
    sec_live_r <= `FSC_SEC_SECURED;
    key_verify_locked_r <= 1'b0;
  end else if (clk_en) begin
    cmd_done_flag <= cmd_done_nxt;
    dbl_fault_flag <= dbl_fault_nxt;
    sgl_fault_flag <= sgl_fault_nxt;
    verify_fault_bits <= verify_fault_nxt;
    security_reg <= security_nxt;
    sec_live_r <= sec_live_nxt;
    key_verify_locked_r <= lock_nxt;
  end
end

// protections and options are not loaded here and sit at their defaults
always @(posedge core_clk or posedge reset) begin
  if (reset) begin
    program_protect_reg <= `FSC_PROT_DEFAULT;
    data_protect_reg <= `FSC_PROT_DEFAULT;
    option_reg <= `FSC_OPT_DEFAULT;
  end
end
endmodule

// ### tb/fsc_array_model.sv
`timescale 1ns/100ps
module fsc_array_model (
  input wire core_clk,
  input wire reset,
  input wire key_blank,
  input wire arr_rd_req,
  input wire arr_op_start,
  input wire [17:0] arr_rd_addr,
  output reg arr_rd_valid,
  output reg [15:0] arr_rd_data,
  output wire arr_op_busy
);
  reg [1:0] busy_r;
  assign arr_op_busy = busy_r != 2'h0;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      arr_rd_valid <= 1'b0;
      arr_rd_data <= 16'h0000;
      busy_r <= 2'h0;
    end else begin
      arr_rd_valid <= arr_rd_req & ~arr_rd_valid;
      // data not valid flips every cycle so stale words never look good
      arr_rd_data <= ~arr_rd_data;
      if (arr_rd_req & ~arr_rd_valid)
        arr_rd_data <= arr_rd_addr[3] ? 16'h8383 :
          key_blank ? 16'hFFFF : {4'h1, arr_rd_addr[3:0], 8'h5A};
      if (arr_op_start)
        busy_r <= 2'h3;
      else if (arr_op_busy)
        busy_r <= busy_r - 2'h1;
    end
  end
endmodule

// ### tb/fsc_monitor.sv
`timescale 1ns/100ps
module fsc_monitor (
  input wire core_clk,
  input wire reset,
  input wire cmd_launch,
  input wire cmd_is_key_verify,
  input wire cmd_done_irq_en,
  input wire dbl_fault_irq_en,
  input wire sgl_fault_irq_en,
  input wire cmd_done_flag,
  input wire dbl_fault_flag,
  input wire sgl_fault_flag,
  input wire cmd_irq,
  input wire err_irq,
  input wire stop_ack,
  input wire cpu_stall,
  input wire cmd_wr_accept,
  input wire read_block,
  input wire key_verify_locked_r,
  input wire [7:0] security_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_cmd_irq_lvl: assert property (cmd_irq ==
    (cmd_done_flag & cmd_done_irq_en)) else $error("cmd irq wrong");
  a_err_irq_lvl: assert property (err_irq ==
    (dbl_fault_flag & dbl_fault_irq_en | sgl_fault_flag & sgl_fault_irq_en))
    else $error("err irq wrong");
  a_stop_defer: assert property (!cmd_done_flag |-> !stop_ack)
    else $error("stop granted while busy");
  a_stall_no_done: assert property (cpu_stall |-> !cmd_done_flag)
    else $error("done during stall");
  a_wr_ignored: assert property (!cmd_done_flag |-> !cmd_wr_accept)
    else $error("write accepted while busy");
  a_read_blocked: assert property (read_block |-> !cmd_done_flag)
    else $error("read block outside verify");
  a_lock_sticky: assert property (key_verify_locked_r |=>
    key_verify_locked_r) else $error("lock dropped");
  a_sec_kept: assert property (read_block |=>
    $stable(security_reg)) else $error("security byte changed");
  a_launch_clears: assert property (cmd_launch && cmd_done_flag &&
    !cmd_is_key_verify |=> !cmd_done_flag) else $error("launch ignored");
  a_init_secure: assert property ($fell(reset) |->
    security_reg == 8'hFF) else $error("not secured at reset");
  c_verify: cover property (read_block);
  c_stop: cover property (stop_ack);
  c_err: cover property (err_irq);
endmodule
bind fsc_ctrl fsc_monitor u_mon (.*);

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
  reg core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, cmd_launch = 1'b0;
  reg cmd_is_key_verify = 0, cmd_reg_wr = 0, cmd_done_irq_en = 0;
  reg dbl_fault_irq_en = 0, sgl_fault_irq_en = 0, dbl_fault_clr = 0;
  reg sgl_fault_clr = 0, stop_req = 0, special_mode = 0;
  reg erase_verify_all_ok = 0, arr_dbl_fault = 0, arr_sgl_fault = 0;
  reg key_blank = 0;
  reg [63:0] key_presented = 64'h0;
  wire arr_rd_req, arr_rd_valid, arr_op_busy, arr_op_start, arr_op_abort;
  wire cmd_done_flag, dbl_fault_flag, sgl_fault_flag, key_verify_locked_r;
  wire cmd_irq, err_irq, stop_ack, cpu_stall, cmd_wr_accept, read_block;
  wire [17:0] arr_rd_addr;
  wire [15:0] arr_rd_data;
  wire [7:0] security_reg, program_protect_reg, data_protect_reg, option_reg;
  wire [1:0] verify_fault_bits, security_state_field, key_access_enable;
  integer miscompares = 0, compares = 0, cyc = 0, n;
  localparam [63:0] GOOD = 64'h165A_145A_125A_105A;
  fsc_ctrl DUT (.*);
  fsc_array_model u_arr (.*);
  always #20 core_clk = ~core_clk;
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tick;
    @(negedge core_clk);
  endtask
  task do_reset;
    begin
      reset = 1;
      #1 chk("abort", arr_op_abort, 1);
      repeat (5) tick;
      reset = 0;
      chk("stall", cpu_stall, 1);
      chk("done", cmd_done_flag, 0);
    end
  endtask
  task wait_done;
    for (n = 0; n < 200 && cmd_done_flag !== 1'b1; n = n + 1) tick;
  endtask
  task launch(input [63:0] k, input v);
    begin
      key_presented = k;
      cmd_is_key_verify = v;
      cmd_launch = 1;
      tick;
      cmd_launch = 0;
    end
  endtask
  task t_init;
    begin
      do_reset;
      repeat (9) tick;
      cmd_reg_wr = 1;
      tick;
      chk("wr_acc", cmd_wr_accept, 0);
      cmd_reg_wr = 0;
      wait_done;
      chk("sec", security_reg, 8'h83);
      chk("key_access_enable", key_access_enable, 2'h2);
    end
  endtask
  task t_cmd;
    begin
      stop_req = 1;
      cmd_done_irq_en = 1;
      launch(0, 0);
      chk("stop", stop_ack, 0);
      chk("cirq", cmd_irq, 0);
      clk_en = 0;
      repeat (10) tick;
      chk("frozen", cmd_done_flag, 0);
      clk_en = 1;
      wait_done;
      tick;
      chk("stop", stop_ack, 1);
      chk("cirq", cmd_irq, 1);
      stop_req = 0;
      cmd_done_irq_en = 0;
      sgl_fault_irq_en = 1;
      arr_sgl_fault = 1;
      tick;
      arr_sgl_fault = 0;
      tick;
      chk("eirq", err_irq, 1);
      sgl_fault_clr = 1;
      tick;
      sgl_fault_clr = 0;
      chk("eirq", err_irq, 0);
    end
  endtask
  task t_keys;
    begin
      launch(64'h1, 1);
      chk("rdblk", read_block, 1);
      tick;
      chk("lock", key_verify_locked_r, 1);
      launch(GOOD, 1);
      tick;
      chk("field", security_state_field, 2'h3);
      do_reset;
      wait_done;
      launch(GOOD, 1);
      tick;
      chk("field", security_state_field, 2'h2);
      chk("sec", security_reg, 8'h83);
    end
  endtask
  task t_faults;
    begin
      arr_dbl_fault = 1;
      dbl_fault_irq_en = 1;
      do_reset;
      wait_done;
      chk("vfault", verify_fault_bits, 2'h3);
      chk("sec", security_reg, 8'hFF);
      chk("field", security_state_field, 2'h3);
      tick;
      chk("eirq", err_irq, 1);
      arr_dbl_fault = 0;
      dbl_fault_clr = 1;
      tick;
      dbl_fault_clr = 0;
      chk("dflag", dbl_fault_flag, 0);
      dbl_fault_irq_en = 0;
      key_blank = 1;
      do_reset;
      wait_done;
      launch(64'hFFFF_FFFF_FFFF_FFFF, 1);
      tick;
      chk("lock", key_verify_locked_r, 1);
      chk("field", security_state_field, 2'h3);
      key_blank = 0;
    end
  endtask
  task t_erase;
    begin
      launch(0, 0);
      do_reset;
      wait_done;
      chk("field", security_state_field, 2'h3);
      special_mode = 1;
      erase_verify_all_ok = 1;
      repeat (2) tick;
      chk("field", security_state_field, 2'h2);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  initial begin
    t_init;
    t_cmd;
    t_keys;
    t_faults;
    t_erase;
    tally_and_finish;
  end
endmodule
